// ===== src/adcc_pkg.sv
// package: register map, field positions, reset values and timing of the converter control
// Behaviour
// - four clock settings: divide 16, 8, 4, osc/4
// - conversion lasts exactly 13 bit periods
// - bit clock divided from instruction clock, or from the oscillator at osc/4
// - clock select latched at conversion start
// - sleep discards clock select
// - reference is always the supply
// - reset sets analog pin select to FF
// - pin select active regardless of power bit
// - channel write deferred until conversion ends
// - sleep discards channel select
// - go starts; done clears go, sets flag
// - clearing go aborts, partial result kept
// - sleep clears go, stops conversion
// - go ignored while power bit clear
// - done flag sticky until software clears
// - result is eight bits
// - sleep sets clock and channel selects to ones, powers down
// - clear result, shift marker, nine shifts end
package adcc_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_RESULT = 8'h04;
    localparam logic [7:0] ADDR_PINS   = 8'h08;
    localparam logic [7:0] ADDR_FLAGS  = 8'h0C;
    localparam logic [7:0] ADDR_ENAB   = 8'h10;
    localparam logic [7:0] ADDR_STAT   = 8'h14;
    // control register fields
    localparam int CTRL_CLK_LSB = 6;
    localparam int CTRL_CH_LSB  = 2;
    localparam int CTRL_GO      = 1;
    localparam int CTRL_PWR     = 0;
    localparam int FLAG_DONE    = 7;
    localparam int ENAB_DONE    = 7;
    // reset values
    localparam logic [1:0] CLK_RESET  = 2'h3;
    localparam logic [3:0] CH_RESET   = 4'hF;
    localparam logic [7:0] PINS_RESET = 8'hFF;
    // clock select codes
    localparam logic [1:0] CLK_DIV16 = 2'h0;
    localparam logic [1:0] CLK_DIV8  = 2'h1;
    localparam logic [1:0] CLK_DIV4  = 2'h2;
    localparam logic [1:0] CLK_OSC4  = 2'h3;
    // divisors in instruction clocks
    localparam logic [4:0] DIV16 = 5'h10;
    localparam logic [4:0] DIV8  = 5'h08;
    localparam logic [4:0] DIV4  = 5'h04;
    // bit periods per conversion and sample periods
    localparam logic [3:0] CONV_PERIODS = 4'hD;
    localparam logic [3:0] SAMPLE_PERIODS = 4'h3;
    // sequencer states
    typedef enum logic [1:0] {
        ADCC_IDLE   = 2'b00,
        ADCC_SAMPLE = 2'b01,
        ADCC_SHIFT  = 2'b10,
        ADCC_FINISH = 2'b11
    } adcc_state_e;
endpackage

// ===== src/adcc_clkdiv.sv
// bit-period tick generator from the instruction clock, or from oscillator ticks at osc/4
`timescale 1ns/10ps
`default_nettype none
module adcc_clkdiv
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic [1:0] sel,
    input  wire logic       osc_tick,
    output logic            tick
);
    typedef struct packed
    {
        logic [4:0] cnt;
        logic       tick;
    } adcc_div_s;

    adcc_div_s st_reg;
    adcc_div_s st_next;
    logic [4:0] div;
    logic       step;

    // divisor and count source per selection
    // four clock settings
    always_comb
    begin
        case (sel)
            adcc_pkg::CLK_DIV16: div = adcc_pkg::DIV16;
            adcc_pkg::CLK_DIV8:  div = adcc_pkg::DIV8;
            adcc_pkg::CLK_DIV4:  div = adcc_pkg::DIV4;
            default:             div = adcc_pkg::DIV4;
        endcase
        step = (sel == adcc_pkg::CLK_OSC4) ? osc_tick : 1'b1;
    end

    // count instruction clocks, or oscillator ticks at osc/4, into one bit period
    // divided from clock
    always_comb
    begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (!run)
        begin
            st_next.cnt = 5'h00;
        end
        else if (step)
        begin
            if (st_reg.cnt == div - 5'h01)
            begin
                st_next.cnt  = 5'h00;
                st_next.tick = 1'b1;
            end
            else
            begin
                st_next.cnt = st_reg.cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign tick = st_reg.tick;
endmodule
`default_nettype wire

// ===== src/adcc_sar.sv
// successive approximation result register with leading-one marker
`timescale 1ns/10ps
`default_nettype none
module adcc_sar
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clear,
    input  wire logic       shift,
    input  wire logic       cmp_in,
    output logic [7:0]      result,
    output logic            marker_out
);
    typedef struct packed
    {
        logic [7:0] res;
        logic [8:0] mark;
        logic       out;
    } adcc_sar_s;

    adcc_sar_s st_reg;
    adcc_sar_s st_next;

    // clear empties the result and parks the marker above bit 7
    // marker shift sequence
    always_comb
    begin
        st_next = st_reg;
        st_next.out = 1'b0;
        if (clear)
        begin
            st_next.res  = 8'h00;
            st_next.mark = 9'h100;
        end
        else if (shift)
        begin
            st_next.out  = st_reg.mark[0];
            st_next.mark = {1'b0, st_reg.mark[8:1]};
            // resolved bit lands where the marker stood; kept apart from
            // the marker so a resolved one is never taken for it
            for (int i = 0; i < 8; i++)
                if (st_reg.mark[i])
                    st_next.res[i] = cmp_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign result     = st_reg.res | st_reg.mark[7:0];
    assign marker_out = st_reg.out;
endmodule
`default_nettype wire

// ===== src/adcc_top.sv
// converter control: APB registers, sequencing, sleep and reset handling
`timescale 1ns/10ps
`default_nettype none
module adcc_top
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sleep_enter,
    input  wire logic        osc_tick,
    input  wire logic        cmp_in,
    output logic [3:0]       mux_channel,
    output logic             sample_en,
    output logic             converter_power_on,
    output logic [7:0]       analog_pin_select,
    output logic             conv_irq
);
    typedef struct packed
    {
        adcc_pkg::adcc_state_e state;
        logic [1:0] conv_clock_select;
        logic [3:0] channel_select;
        logic [3:0] chan_active;
        logic       chan_pending;
        logic [3:0] chan_wr;
        logic [1:0] clk_active;
        logic       go;
        logic       power;
        logic [7:0] pins;
        logic       conversion_done_flag;
        logic       conversion_irq_enable;
        logic [3:0] periods;
        logic [31:0] rdata;
        logic       ready;
        logic       err;
        logic       irq;
        logic       sample;
        logic       sleep_s1;
        logic       sleep_s2;
        logic       cmp_s1;
        logic       cmp_s2;
        logic       osc_s1;
        logic       osc_s2;
    } adcc_top_s;

    adcc_top_s st_reg;
    adcc_top_s st_next;
    logic       tick;
    logic       sar_clear;
    logic       sar_shift;
    logic [7:0] result;
    logic       marker_out;
    logic       wr_acc;
    logic       rd_acc;
    logic       running;

    // register decode hit check
    function automatic logic adcc_mapped(input logic [7:0] a);
        adcc_mapped = (a == adcc_pkg::ADDR_CTRL) || (a == adcc_pkg::ADDR_RESULT) ||
                      (a == adcc_pkg::ADDR_PINS) || (a == adcc_pkg::ADDR_FLAGS) ||
                      (a == adcc_pkg::ADDR_ENAB) || (a == adcc_pkg::ADDR_STAT);
    endfunction

    assign running = (st_reg.state != adcc_pkg::ADCC_IDLE);
    assign wr_acc  = psel && penable && pwrite && !st_reg.ready;
    assign rd_acc  = psel && penable && !pwrite && !st_reg.ready;

    // bit-period generator runs only during a conversion
    // latched clock select
    adcc_clkdiv u_div
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .run      (running),
        .sel      (st_reg.clk_active),
        .osc_tick (st_reg.osc_s2),
        .tick     (tick)
    );

    adcc_sar u_sar
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .clear      (sar_clear),
        .shift      (sar_shift),
        .cmp_in     (st_reg.cmp_s2),
        .result     (result),
        .marker_out (marker_out)
    );

    // sequencer strobes toward the approximation register
    always_comb
    begin
        sar_clear = (st_reg.state == adcc_pkg::ADCC_SAMPLE) && tick &&
                    (st_reg.periods == adcc_pkg::SAMPLE_PERIODS - 4'h1);
        sar_shift = (st_reg.state == adcc_pkg::ADCC_SHIFT) && tick;
    end

    // next-state: bus, synchronisers, sequencer, sleep
    always_comb
    begin
        st_next = st_reg;
        // pin inputs through two flops
        st_next.sleep_s1 = sleep_enter;
        st_next.sleep_s2 = st_reg.sleep_s1;
        st_next.cmp_s1   = cmp_in;
        st_next.cmp_s2   = st_reg.cmp_s1;
        st_next.osc_s1   = osc_tick;
        st_next.osc_s2   = st_reg.osc_s1;
        st_next.ready    = 1'b0;
        st_next.err      = 1'b0;

        // sequencer: 3 sample periods then 10 shift periods
        // thirteen bit periods
        case (st_reg.state)
            adcc_pkg::ADCC_IDLE:
            begin
                st_next.periods = 4'h0;
            end
            adcc_pkg::ADCC_SAMPLE:
            begin
                if (tick)
                begin
                    st_next.periods = st_reg.periods + 4'h1;
                    if (st_reg.periods == adcc_pkg::SAMPLE_PERIODS - 4'h1)
                        st_next.state = adcc_pkg::ADCC_SHIFT;
                end
            end
            adcc_pkg::ADCC_SHIFT:
            begin
                if (tick)
                begin
                    st_next.periods = st_reg.periods + 4'h1;
                    if (st_reg.periods == adcc_pkg::CONV_PERIODS - 4'h1)
                        st_next.state = adcc_pkg::ADCC_FINISH;
                end
            end
            adcc_pkg::ADCC_FINISH:
            begin
                st_next.go = 1'b0;
                st_next.conversion_done_flag = 1'b1;
                st_next.state = adcc_pkg::ADCC_IDLE;
            end
            default:
            begin
                st_next.state = adcc_pkg::ADCC_IDLE;
            end
        endcase
        // deferred channel takes effect once idle
        // deferred channel write
        if (st_reg.state == adcc_pkg::ADCC_FINISH && st_reg.chan_pending)
        begin
            st_next.channel_select = st_reg.chan_wr;
            st_next.chan_pending   = 1'b0;
        end

        // register writes
        if (wr_acc)
        begin
            st_next.ready = 1'b1;
            st_next.err   = !adcc_mapped(paddr);
            case (paddr)
                adcc_pkg::ADDR_CTRL:
                begin
                    st_next.conv_clock_select = pwdata[adcc_pkg::CTRL_CLK_LSB +: 2];
                    st_next.power = pwdata[adcc_pkg::CTRL_PWR];
                    if (running && st_reg.state != adcc_pkg::ADCC_FINISH)
                    begin
                        st_next.chan_wr      = pwdata[adcc_pkg::CTRL_CH_LSB +: 4];
                        st_next.chan_pending = 1'b1;
                    end
                    else
                    begin
                        st_next.channel_select = pwdata[adcc_pkg::CTRL_CH_LSB +: 4];
                    end
                    if (!pwdata[adcc_pkg::CTRL_GO] && running)
                    begin
                        st_next.go    = 1'b0;
                        st_next.state = adcc_pkg::ADCC_IDLE;
                        st_next.chan_pending = 1'b0;
                        st_next.channel_select = pwdata[adcc_pkg::CTRL_CH_LSB +: 4];
                    end
                    else if (pwdata[adcc_pkg::CTRL_GO] && pwdata[adcc_pkg::CTRL_PWR] &&
                             !running)
                    begin
                        st_next.go          = 1'b1;
                        st_next.state       = adcc_pkg::ADCC_SAMPLE;
                        st_next.clk_active  = pwdata[adcc_pkg::CTRL_CLK_LSB +: 2];
                        st_next.chan_active = pwdata[adcc_pkg::CTRL_CH_LSB +: 4];
                    end
                end
                adcc_pkg::ADDR_PINS:
                    st_next.pins = pwdata[7:0];
                adcc_pkg::ADDR_FLAGS:
                    if (!(st_reg.state == adcc_pkg::ADCC_FINISH))
                        st_next.conversion_done_flag = pwdata[adcc_pkg::FLAG_DONE];
                adcc_pkg::ADDR_ENAB:
                    st_next.conversion_irq_enable = pwdata[adcc_pkg::ENAB_DONE];
                default:
                begin
                end
            endcase
        end

        // register reads
        if (rd_acc)
        begin
            st_next.ready = 1'b1;
            st_next.err   = !adcc_mapped(paddr);
            case (paddr)
                adcc_pkg::ADDR_CTRL:
                    st_next.rdata = {24'h000000, st_reg.conv_clock_select,
                                     st_reg.channel_select, st_reg.go, st_reg.power};
                adcc_pkg::ADDR_RESULT:
                    st_next.rdata = {24'h000000, result};
                adcc_pkg::ADDR_PINS:
                    st_next.rdata = {24'h000000, st_reg.pins};
                adcc_pkg::ADDR_FLAGS:
                    st_next.rdata = {24'h000000, st_reg.conversion_done_flag, 7'h00};
                adcc_pkg::ADDR_ENAB:
                    st_next.rdata = {24'h000000, st_reg.conversion_irq_enable, 7'h00};
                adcc_pkg::ADDR_STAT:
                    st_next.rdata = {28'h0000000, st_reg.chan_pending,
                                     st_reg.chan_active[0], st_reg.state};
                default:
                    st_next.rdata = 32'h00000000;
            endcase
        end

        // sleep entry overrides control register writes and the sequencer
        // sleep stops conversion
        if (st_reg.sleep_s2)
        begin
            st_next.go    = 1'b0;
            st_next.state = adcc_pkg::ADCC_IDLE;
            st_next.power = 1'b0;
            st_next.conv_clock_select = adcc_pkg::CLK_RESET;
            st_next.channel_select = adcc_pkg::CH_RESET;
            st_next.chan_pending   = 1'b0;
        end

        st_next.irq    = st_next.conversion_done_flag && st_next.conversion_irq_enable;
        st_next.sample = (st_next.state == adcc_pkg::ADCC_SAMPLE);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg <= '0;
            st_reg.conv_clock_select <= adcc_pkg::CLK_RESET;
            st_reg.channel_select    <= adcc_pkg::CH_RESET;
            st_reg.chan_active       <= adcc_pkg::CH_RESET;
            st_reg.clk_active        <= adcc_pkg::CLK_RESET;
            st_reg.pins              <= adcc_pkg::PINS_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // outputs from flops; reference is fixed to supply, no pin
    // supply reference
    assign prdata             = st_reg.rdata;
    assign pready             = st_reg.ready;
    assign pslverr            = st_reg.err;
    assign mux_channel        = st_reg.chan_active;
    assign sample_en          = st_reg.sample;
    assign converter_power_on = st_reg.power;
    assign analog_pin_select  = st_reg.pins;
    assign conv_irq           = st_reg.irq;

    // done flag set the cycle after a finish state unless sleep is active
    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.state == adcc_pkg::ADCC_FINISH && !st_reg.sleep_s2) |=> st_reg.conversion_done_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("done flag not set");
    property p_go_power;
        @(posedge pclk) disable iff (!presetn)
        $rose(st_reg.go) |-> st_reg.power;
    endproperty
    a_go_power: assert property (p_go_power) else $error("go set without power");
    property p_sleep;
        @(posedge pclk) disable iff (!presetn)
        st_reg.sleep_s2 |=> !st_reg.go && !st_reg.power && st_reg.channel_select == 4'hF;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep did not clear state");
    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        conv_irq |-> st_reg.conversion_irq_enable && st_reg.conversion_done_flag;
    endproperty
    a_irq: assert property (p_irq) else $error("irq without enable");
    property p_chan_hold;
        @(posedge pclk) disable iff (!presetn)
        (running && $stable(running)) |-> $stable(st_reg.chan_active);
    endproperty
    a_chan_hold: assert property (p_chan_hold) else $error("channel moved mid conversion");
    property p_clk_hold;
        @(posedge pclk) disable iff (!presetn)
        (running && $past(running)) |-> $stable(st_reg.clk_active);
    endproperty
    a_clk_hold: assert property (p_clk_hold) else $error("clock moved mid conversion");
    property p_ready;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("apb answer late");
    property p_flag_sticky;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.conversion_done_flag && !(psel && pwrite && paddr == adcc_pkg::ADDR_FLAGS))
        |=> st_reg.conversion_done_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");
    property p_marker;
        @(posedge pclk) disable iff (!presetn)
        marker_out |-> st_reg.periods == adcc_pkg::CONV_PERIODS - 4'h1;
    endproperty
    a_marker: assert property (p_marker) else $error("marker left at wrong step");
endmodule
`default_nettype wire

// ===== verif/adcc_front_model.sv
// analog front end model: comparator decisions and oscillator ticks
`timescale 1ns/10ps
`default_nettype none
module adcc_front_model
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] mux_channel,
    input  wire logic       converter_power_on,
    output logic            osc_tick,
    output logic            cmp_in
);
    logic [2:0] cnt;
    logic       tog;
    // ----------------------------------------
    // oscillator and noise
    // ----------------------------------------
    // tick every 6 clocks, toggling noise
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 3'h0;
            tog <= 1'b0;
        end
        else
        begin
            cnt <= (cnt == 3'h5) ? 3'h0 : cnt + 3'h1;
            tog <= ~tog;
        end
    end
    assign osc_tick = (cnt == 3'h5);
    // supply reference, odd channels full scale
    assign cmp_in = converter_power_on ? mux_channel[0] : tog; // noise when off
endmodule
`default_nettype wire

// ===== verif/adc_conversion_control_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_control_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        sleep_enter = 1'b0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, osc_tick, cmp_in, sample_en, converter_power_on;
    logic        conv_irq, irq_d;
    logic [3:0]  mux_channel;
    logic [7:0]  analog_pin_select;
    logic [31:0] seed = 32'h17AC;
    logic [33:0] ev;
    logic [33:0] eq[$];
    int          tq[$];
    int          dv[4] = '{16, 8, 4, 24};
    int          mismatches = 0;
    int          compares = 0;
    int          sc = 0;
    int          tc = 0;
    always #2 pclk = ~pclk;
    adcc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleep_enter(sleep_enter),
        .osc_tick(osc_tick), .cmp_in(cmp_in), .mux_channel(mux_channel),
        .sample_en(sample_en), .converter_power_on(converter_power_on),
        .analog_pin_select(analog_pin_select), .conv_irq(conv_irq));
    adcc_front_model front (.pclk(pclk), .presetn(presetn), .mux_channel(mux_channel),
        .converter_power_on(converter_power_on), .osc_tick(osc_tick), .cmp_in(cmp_in));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic fail(input string m);
        mismatches++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic conclude;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e)
            fail("port value");
    endtask
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] ctl(logic [1:0] c, logic [3:0] h, logic g, logic p);
        return {24'h0, c, h, g, p};
    endfunction
    // one apb transfer, noting the expected answer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic c, input logic [31:0] e, input logic er);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        eq.push_back({c, er, e});
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            fail("no ready");
            conclude();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0, 32'h0, 1'b0);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 1'b1, e, 1'b0);
    endtask
    task automatic wait_irq;
        int n;
        for (n = 0; n < 2000 && conv_irq !== 1'b1; n++)
            @(posedge pclk);
        if (n >= 2000)
        begin
            fail("no completion");
            conclude();
        end
    endtask
    // ----------------------------------------
    // result watchers
    // ----------------------------------------
    // apb answers against the oldest note
    always @(posedge pclk)
    begin
        if (pready === 1'b1 && eq.size() > 0)
        begin
            ev = eq.pop_front();
            if (ev[33])
            begin
                compares++;
                if (prdata !== ev[31:0] || pslverr !== ev[32])
                    fail("read data");
            end
        end
    end
    // sampling width and conversion length in clocks
    always @(posedge pclk)
    begin
        if (sample_en === 1'b1)
            sc = sc + 1;
        if (sc == 1)
            tc = 0;
        tc = tc + 1;
        if (sample_en !== 1'b1 && sc > 0 && tq.size() > 0)
        begin
            compares++;
            if (sc < 3 * tq[0] - 8 || sc > 3 * tq[0] + 8)
                fail("sample width");
        end
        if (sample_en !== 1'b1)
            sc = 0;
        if (conv_irq === 1'b1 && irq_d !== 1'b1 && tq.size() > 0)
        begin
            compares++;
            if (tc < 13 * tq[0] - 8 || tc > 13 * tq[0] + 8)
                fail("conversion length");
            tq.delete(0);
        end
        irq_d = conv_irq;
    end
    initial
    begin
        #400000;
        fail("timeout");
        conclude();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        logic [7:0] v;
        logic [2:0] ch;
        int         s;
        cyc(20);
        presetn <= 1'b1;
        rdc(adcc_pkg::ADDR_CTRL, 32'hFC);
        rdc(adcc_pkg::ADDR_PINS, 32'hFF);
        rdc(adcc_pkg::ADDR_FLAGS, 32'h00);
        rdc(adcc_pkg::ADDR_ENAB, 32'h00);
        apb(1'b0, 8'h18, 32'h0, 1'b1, 32'h0, 1'b1);
        v = 8'(rnd());
        wr(adcc_pkg::ADDR_PINS, {24'h0, v});
        rdc(adcc_pkg::ADDR_PINS, {24'h0, v});
        cmp8(analog_pin_select, v);
        wr(adcc_pkg::ADDR_PINS, 32'hFF);
        wr(adcc_pkg::ADDR_CTRL, ctl(2'h3, 4'h1, 1'b1, 1'b0));
        rdc(adcc_pkg::ADDR_CTRL, ctl(2'h3, 4'h1, 1'b0, 1'b0));
        wr(adcc_pkg::ADDR_ENAB, 32'h80);
        // every clock setting, internal oscillator last
        for (s = 0; s < 4; s++)
        begin
            ch = 3'(rnd());
            wr(adcc_pkg::ADDR_CTRL, ctl(2'(s), {1'b0, ch}, 1'b0, 1'b1));
            cyc(20);
            tq.push_back(dv[s]);
            wr(adcc_pkg::ADDR_CTRL, ctl(2'(s), {1'b0, ch}, 1'b1, 1'b1));
            wait_irq();
            rdc(adcc_pkg::ADDR_RESULT, ch[0] ? 32'hFF : 32'h00);
            rdc(adcc_pkg::ADDR_CTRL, ctl(2'(s), {1'b0, ch}, 1'b0, 1'b1));
            cyc(30);
            rdc(adcc_pkg::ADDR_FLAGS, 32'h80);
            wr(adcc_pkg::ADDR_FLAGS, 32'h00);
            rdc(adcc_pkg::ADDR_FLAGS, 32'h00);
        end
        wr(adcc_pkg::ADDR_CTRL, ctl(2'h0, 4'h1, 1'b0, 1'b1));
        cyc(20);
        tq.push_back(16);
        wr(adcc_pkg::ADDR_CTRL, ctl(2'h0, 4'h1, 1'b1, 1'b1));
        cyc(30);
        wr(adcc_pkg::ADDR_CTRL, ctl(2'h2, 4'h2, 1'b1, 1'b1));
        wait_irq();
        rdc(adcc_pkg::ADDR_RESULT, 32'hFF);
        rdc(adcc_pkg::ADDR_CTRL, ctl(2'h2, 4'h2, 1'b0, 1'b1));
        wr(adcc_pkg::ADDR_FLAGS, 32'h00);
        cyc(20);
        tq.push_back(4);
        wr(adcc_pkg::ADDR_CTRL, ctl(2'h2, 4'h2, 1'b1, 1'b1));
        wait_irq();
        rdc(adcc_pkg::ADDR_RESULT, 32'h00);
        cmp8({4'h0, mux_channel}, 8'h02);
        wr(adcc_pkg::ADDR_FLAGS, 32'h00);
        wr(adcc_pkg::ADDR_ENAB, 32'h00);
        wr(adcc_pkg::ADDR_CTRL, ctl(2'h2, 4'h3, 1'b1, 1'b1));
        cyc(25);
        wr(adcc_pkg::ADDR_CTRL, ctl(2'h2, 4'h3, 1'b0, 1'b1));
        cyc(100);
        rdc(adcc_pkg::ADDR_FLAGS, 32'h00);
        wr(adcc_pkg::ADDR_CTRL, ctl(2'h2, 4'h3, 1'b1, 1'b1));
        for (s = 0; s < 100; s++)
        begin
            apb(1'b0, adcc_pkg::ADDR_CTRL, 32'h0, 1'b0, 32'h0, 1'b0);
            if (rd[1] === 1'b0)
                break;
        end
        rdc(adcc_pkg::ADDR_FLAGS, 32'h80);
        cmp8({7'h0, conv_irq}, 8'h00);
        wr(adcc_pkg::ADDR_ENAB, 32'h80);
        cyc(3);
        cmp8({7'h0, conv_irq}, 8'h01);
        wr(adcc_pkg::ADDR_FLAGS, 32'h00);
        wr(adcc_pkg::ADDR_PINS, 32'h5A);
        wr(adcc_pkg::ADDR_CTRL, ctl(2'h1, 4'h5, 1'b1, 1'b1));
        cyc(20);
        sleep_enter <= 1'b1;
        cyc(8);
        sleep_enter <= 1'b0;
        cyc(4);
        rdc(adcc_pkg::ADDR_CTRL, 32'hFC);
        rdc(adcc_pkg::ADDR_PINS, 32'h5A);
        cmp8({7'h0, converter_power_on}, 8'h00);
        rdc(adcc_pkg::ADDR_FLAGS, 32'h00);
        conclude();
    end
endmodule
`default_nettype wire
